// >>> rtl/pan_pkg.sv
// Shared constants and carrier types for the autonegotiation ability register bank
package pan_pkg;

    localparam int PAN_NUM_PORTS = 2;
    localparam int PAN_ADDR_W = 12;

    // Register indices; the byte offset of a register within its port window is four times its index
    localparam logic [3:0] PAN_IDX_IDENT_LOW = 4'h3;
    localparam logic [3:0] PAN_IDX_ADVERTISE = 4'h4;
    localparam logic [3:0] PAN_IDX_PARTNER = 4'h5;
    localparam logic [3:0] PAN_IDX_EXPANSION = 4'h6;

    // Each port owns one window of the address space
    localparam logic [11:0] PAN_PORT_STRIDE = 12'h040;
    localparam logic [11:0] PAN_IRQ_STAT_ADDR = 12'h100;
    localparam logic [11:0] PAN_IRQ_MASK_ADDR = 12'h104;

    // Arbitrary neutral identifier value
    localparam logic [15:0] PAN_IDENT_LOW_DEF = 16'h5a5a;

    // Advertisement layout
    localparam int PAN_ADV_NEXT_PAGE = 15;
    localparam int PAN_ADV_REMOTE_FAULT = 13;
    localparam int PAN_ADV_T4 = 9;
    localparam logic [15:0] PAN_ADV_RESET = 16'h05e1;
    localparam logic [15:0] PAN_ADV_WMASK = 16'hadff;

    // Partner ability layout
    localparam int PAN_LPA_NEXT_PAGE = 15;
    localparam int PAN_LPA_ACK = 14;
    localparam logic [15:0] PAN_LPA_RESET = 16'h0000;

    // Expansion status layout
    localparam int PAN_EXP_PDF = 4;
    localparam int PAN_EXP_LP_NP = 3;
    localparam int PAN_EXP_LOC_NP = 2;
    localparam int PAN_EXP_PAGE_RX = 1;
    localparam int PAN_EXP_LP_AN = 0;

    // Interrupt status: per port, bit 0 page received, bit 1 parallel detection fault
    localparam int PAN_IRQ_PER_PORT = 2;
    localparam int PAN_IRQ_PAGE = 0;
    localparam int PAN_IRQ_PDF = 1;

    // Events from the negotiation engine of one port, same clock
    typedef struct packed {
        logic page_valid;
        logic [15:0] page_word;
        logic par_det_fault;
        logic partner_an_able;
    } pan_an_in_t;

    typedef struct packed {
        logic hit;
        logic irq_stat;
        logic irq_mask;
        logic port;
        logic [3:0] idx;
    } pan_dec_t;

endpackage

// >>> rtl/pan_regs.sv
// APB register bank for per-port autonegotiation ability, partner and expansion state
`timescale 1ns/100ps
`default_nettype none
module pan_regs #(
    parameter int NUM_PORTS = pan_pkg::PAN_NUM_PORTS,
    parameter logic [15:0] IDENT_LOW = pan_pkg::PAN_IDENT_LOW_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pan_pkg::PAN_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pan_pkg::pan_an_in_t an_in [NUM_PORTS],
    output logic [15:0] adv_word [NUM_PORTS],
    output logic irq
);
    import pan_pkg::*;

    localparam int IRQ_W = NUM_PORTS * PAN_IRQ_PER_PORT;

    logic [15:0] adv_q [NUM_PORTS];
    logic [15:0] lpa_q [NUM_PORTS];
    logic [NUM_PORTS-1:0] page_rx_q;
    logic [NUM_PORTS-1:0] pdf_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    pan_dec_t dec_q;
    pan_dec_t dec;
    logic [31:0] rd_data;
    logic setup;
    logic wr_done;
    logic rd_done;
    logic [15:0] wmask;
    logic [IRQ_W-1:0] irq_set;

    // Address decode shared by the setup phase
    function automatic pan_dec_t decode(input logic [PAN_ADDR_W-1:0] a);
        pan_dec_t d;
        logic [PAN_ADDR_W-1:0] off;
        d = '0;
        off = a;
        if (a == PAN_IRQ_STAT_ADDR) begin
            d.hit = 1'b1;
            d.irq_stat = 1'b1;
        end else if (a == PAN_IRQ_MASK_ADDR) begin
            d.hit = 1'b1;
            d.irq_mask = 1'b1;
        end else if (a < PAN_PORT_STRIDE * NUM_PORTS[PAN_ADDR_W-1:0]) begin
            d.port = (a >= PAN_PORT_STRIDE);
            off = d.port ? a - PAN_PORT_STRIDE : a;
            d.idx = off[5:2];
            d.hit = (off[1:0] == 2'b00) && (off[5:2] >= PAN_IDX_IDENT_LOW) &&
                    (off[5:2] <= PAN_IDX_EXPANSION);
        end
        return d;
    endfunction

    function automatic logic [15:0] expansion(input int p);
        logic [15:0] e;
        e = '0;
        e[PAN_EXP_PDF] = pdf_q[p];
        e[PAN_EXP_LP_NP] = lpa_q[p][PAN_LPA_NEXT_PAGE];
        e[PAN_EXP_LOC_NP] = adv_q[p][PAN_ADV_NEXT_PAGE];
        e[PAN_EXP_PAGE_RX] = page_rx_q[p];
        e[PAN_EXP_LP_AN] = an_in[p].partner_an_able;
        return e;
    endfunction

    assign setup = psel && !penable;
    assign wr_done = psel && penable && pready_q && pwrite && dec_q.hit;
    assign rd_done = psel && penable && pready_q && !pwrite && dec_q.hit;
    assign dec = decode(paddr);
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        rd_data = '0;
        if (dec.irq_stat) begin
            rd_data[IRQ_W-1:0] = irq_stat_q;
        end else if (dec.irq_mask) begin
            rd_data[IRQ_W-1:0] = irq_mask_q;
        end else if (dec.hit && dec.idx == PAN_IDX_IDENT_LOW) begin
            rd_data[15:0] = IDENT_LOW;
        end else if (dec.hit && dec.idx == PAN_IDX_ADVERTISE) begin
            rd_data[15:0] = adv_q[dec.port];
        end else if (dec.hit && dec.idx == PAN_IDX_PARTNER) begin
            rd_data[15:0] = lpa_q[dec.port];
        end else if (dec.hit && dec.idx == PAN_IDX_EXPANSION) begin
            rd_data[15:0] = expansion(int'(dec.port));
        end
    end

    // Zero-wait slave: data is captured in setup, so pready is high on the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            dec_q <= '0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr_q <= !dec.hit;
                dec_q <= dec;
            end
        end
    end

    // Advertisement is what the engine sends after software restarts negotiation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                adv_q[p] <= PAN_ADV_RESET;
            end
        end else if (wr_done && !dec_q.irq_stat && !dec_q.irq_mask &&
                     dec_q.idx == PAN_IDX_ADVERTISE) begin
            adv_q[dec_q.port] <= (adv_q[dec_q.port] & ~(PAN_ADV_WMASK & wmask)) |
                                 (pwdata[15:0] & PAN_ADV_WMASK & wmask);
        end
    end

    // Partner word only changes on a received page; acknowledge and fault come with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                lpa_q[p] <= PAN_LPA_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (an_in[p].page_valid) begin
                    lpa_q[p] <= an_in[p].page_word;
                end
            end
        end
    end

    // Only bits that were actually returned are cleared, so nothing raised after
    // the setup capture is lost; a live condition re-sets the bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_rx_q <= '0;
            pdf_q <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (an_in[p].page_valid) begin
                    page_rx_q[p] <= 1'b1;
                end else if (rd_done && !dec_q.irq_stat && !dec_q.irq_mask &&
                             dec_q.idx == PAN_IDX_EXPANSION && int'(dec_q.port) == p &&
                             prdata_q[PAN_EXP_PAGE_RX]) begin
                    page_rx_q[p] <= 1'b0;
                end
                if (an_in[p].par_det_fault) begin
                    pdf_q[p] <= 1'b1;
                end else if (rd_done && !dec_q.irq_stat && !dec_q.irq_mask &&
                             dec_q.idx == PAN_IDX_EXPANSION && int'(dec_q.port) == p &&
                             prdata_q[PAN_EXP_PDF]) begin
                    pdf_q[p] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        irq_set = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            irq_set[p*PAN_IRQ_PER_PORT+PAN_IRQ_PAGE] = an_in[p].page_valid;
            irq_set[p*PAN_IRQ_PER_PORT+PAN_IRQ_PDF] = an_in[p].par_det_fault;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else if (rd_done && dec_q.irq_stat) begin
            irq_stat_q <= (irq_stat_q & ~prdata_q[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= '0;
        end else if (wr_done && dec_q.irq_mask && pstrb[0]) begin
            irq_mask_q <= pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign adv_word = adv_q;

endmodule
`default_nettype wire

// >>> tb/pan_regs_properties.sv
// Port assertions for the autonegotiation register bank
`timescale 1ns/100ps
`default_nettype none
module pan_regs_properties #(
    parameter int NUM_PORTS = 2,
    parameter logic [15:0] IDENT_LOW = 16'h0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] adv_word [NUM_PORTS]
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy)
        else $error("no pready after setup");
    property p_one; pready |-> psel && penable && $past(psel && !penable); endproperty
    a_one: assert property (p_one)
        else $error("pready outside first access cycle");
    property p_rst; $rose(presetn) |-> adv_word[0] == 16'h05e1 && adv_word[1] == 16'h05e1; endproperty
    a_rst: assert property (p_rst)
        else $error("advertisement reset value wrong");
    property p_ro; ((adv_word[0] | adv_word[1]) & 16'h5200) == 16'h0; endproperty
    a_ro: assert property (p_ro)
        else $error("fixed advertisement bit set");
    property p_id; pready && !pwrite && paddr == 12'h00c |-> prdata == {16'h0, IDENT_LOW}; endproperty
    a_id: assert property (p_id)
        else $error("identifier word wrong");
    property p_rsv; pready && !pwrite && paddr[5:0] == 6'h18 |-> prdata[31:5] == 27'h0; endproperty
    a_rsv: assert property (p_rsv)
        else $error("expansion upper bits set");
    property p_map; pready && paddr == 12'h000 |-> pslverr && prdata == 32'h0; endproperty
    a_map: assert property (p_map)
        else $error("unmapped access not refused");
    property p_wr;
        pready && pwrite && pstrb == 4'hf && paddr == 12'h010
            |=> adv_word[0] == ($past(pwdata[15:0]) & 16'hadff);
    endproperty
    a_wr: assert property (p_wr)
        else $error("advertisement write not applied");
endmodule
bind pan_regs pan_regs_properties #(.NUM_PORTS(NUM_PORTS), .IDENT_LOW(IDENT_LOW)) u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .adv_word);
`default_nettype wire

// >>> tb/pan_link_partner.sv
// Remote link partner model feeding negotiation events of one port
`timescale 1ns/100ps
`default_nettype none
module pan_link_partner (
    input wire logic pclk,
    input wire logic send,
    input wire logic [15:0] word,
    input wire logic fault,
    input wire logic able,
    output pan_pkg::pan_an_in_t an_out
);
    import pan_pkg::*;
    logic [15:0] last_q = 16'h0;
    always_ff @(posedge pclk) begin
        if (send) begin
            last_q <= word;
        end
    end
    // Outside the pulse the word is garbage so a sloppy capture shows up
    always_comb begin
        an_out.page_valid = send;
        an_out.page_word = send ? word : ~last_q;
        an_out.par_det_fault = fault;
        an_out.partner_an_able = able;
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the autonegotiation register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pan_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    pan_an_in_t an_in [2];
    logic [15:0] adv_word [2];
    logic [1:0] send = 2'b0;
    logic [1:0] fault = 2'b0;
    logic [1:0] able = 2'b0;
    logic [15:0] word [2] = '{16'h0, 16'h0};
    logic [15:0] advm [2] = '{16'h05e1, 16'h05e1};
    logic [31:0] seed = 32'd68;
    logic [31:0] r;
    logic e;
    logic [15:0] w;
    logic [3:0] s;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    always #2 pclk = ~pclk;
    pan_regs #(.NUM_PORTS(2), .IDENT_LOW(PAN_IDENT_LOW_DEF)) uut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .an_in,
        .adv_word, .irq);
    for (genvar g = 0; g < 2; g++) begin : g_lp
        pan_link_partner u_lp (.pclk, .send(send[g]), .word(word[g]), .fault(fault[g]),
            .able(able[g]), .an_out(an_in[g]));
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Only writable bits under an enabled byte lane may change
    function automatic logic [15:0] adv_exp(input logic [15:0] o, v, input logic [3:0] b);
        logic [15:0] m;
        m = PAN_ADV_WMASK & {{8{b[1]}}, {8{b[0]}}};
        return (o & ~m) | (v & m);
    endfunction
    function automatic logic [31:0] exp_x(input logic pdf, lnp, np, pr, an);
        return {27'h0, pdf, lnp, np, pr, an};
    endfunction
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] b);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= b;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(r, x);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            rd(12'(p * 64 + 12), {16'h0, PAN_IDENT_LOW_DEF});
            rd(12'(p * 64 + 16), 32'h05e1);
            rd(12'(p * 64 + 20), 32'h0);
            rd(12'(p * 64 + 24), 32'h0);
        end
        rd(12'h104, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            w = (i < 2) ? {16{~i[0]}} : seed[15:0];
            s = (i < 2) ? 4'hf : seed[19:16];
            advm[i % 2] = adv_exp(advm[i % 2], w, s);
            apb(1'b1, 12'(i % 2 * 64 + 16), {seed[31:16], w}, s);
            rd(12'(i % 2 * 64 + 16), {16'h0, advm[i % 2]});
            chk({16'h0, adv_word[i % 2]}, {16'h0, advm[i % 2]});
        end
        apb(1'b1, 12'h04c, seed, 4'hf);
        rd(12'h04c, {16'h0, PAN_IDENT_LOW_DEF});
        $display("test write done");
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 12'h03c, seed, 4'hf);
        chk({31'h0, e}, 32'h1);
        $display("test unmapped done");
        apb(1'b1, 12'h104, 32'h1, 4'hf);
        seed = xs(seed);
        word[0] <= seed[15:0];
        send[0] <= 1'b1;
        able[0] <= 1'b1;
        @(posedge pclk);
        send[0] <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd(12'h014, {16'h0, seed[15:0]});
        rd(12'h018, exp_x(1'b0, seed[15], advm[0][15], 1'b1, 1'b1));
        rd(12'h018, exp_x(1'b0, seed[15], advm[0][15], 1'b0, 1'b1));
        rd(12'h100, 32'h1);
        rd(12'h100, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test page done");
        fault[1] <= 1'b1;
        @(posedge pclk);
        rd(12'h058, exp_x(1'b1, 1'b0, advm[1][15], 1'b0, 1'b0));
        rd(12'h058, exp_x(1'b1, 1'b0, advm[1][15], 1'b0, 1'b0));
        fault[1] <= 1'b0;
        @(posedge pclk);
        rd(12'h058, exp_x(1'b1, 1'b0, advm[1][15], 1'b0, 1'b0));
        rd(12'h058, exp_x(1'b0, 1'b0, advm[1][15], 1'b0, 1'b0));
        rd(12'h100, 32'h8);
        chk({31'h0, irq}, 32'h0);
        $display("test fault done");
        close_out();
    end
endmodule
`default_nettype wire
